//--- rtl/amp_ctl_consts.vh
// Constants for the amplifier control port two-wire slave
`ifndef AMP_CTL_CONSTS_VH
`define AMP_CTL_CONSTS_VH
`define ADDR_UPPER          5'h0D
`define REG_SYSTEM_INTERRUPT_REG          8'h02
`define REG_SUPPLY          8'h21
`define REG_HEAT            8'h22
`define REG_ID              8'h00
`define UNDERVOLTAGE_INT_FLAG_BIT            14
`define SYS_CLK_NS          40
`define MIN_SCL_PERIOD_NS   2500
`define MIN_SCL_CYC         ((`MIN_SCL_PERIOD_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`endif

//--- rtl/amp_i2c_control_slave.v
// Two-wire control slave of the amplifier with its status readouts
`timescale 1ns/100ps
`include "amp_ctl_consts.vh"
// Notes on behaviour
// - Slave only; bus clock sampled at 25 MHz supports 400 kHz operation.
// - Answers 7-bit address 01101 plus select pins bit1, bit0.
// - Data driven changes only while clock is low.
// - Data falling while clock high is taken as start.
// - Data rising while clock high is taken as stop.
// - Device pulls data low during ninth clock after master's eight bits.
// - Read: eight bits out, release line, sample master acknowledge.
// - Master acknowledge without stop continues with next byte.
// - Missing master acknowledge: release line, idle until stop.
// - Undervoltage flag set by event, cleared when interrupt register read.
// - Supply level is unsigned ten-bit code, all-ones means 6.025 V.
// - Die temperature reported as two's complement code.
// - Register pointer advances by one per further written value.
// - Data change while clock high mid-transfer abandons the transaction.
module amp_i2c_control_slave #(
  parameter ID_CODE = 16'h0A5C  // Arbitrary identity value
) (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  // Bus pins (open drain)
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe_n,
  // Address straps
  input  wire        addr_select_bit0_pin,
  input  wire        addr_select_bit1_pin,
  // Status sources
  input  wire        undervoltage_event,
  input  wire [9:0]  supply_level_code,
  input  wire [7:0]  die_heat_code,
  // Register write port
  output reg         wr_strobe,
  output reg  [7:0]  wr_addr,
  output reg  [15:0] wr_data,
  // Status outputs
  output reg         undervoltage_int_flag,
  output wire        busy
);

  localparam ST_IDLE = 6'h01;
  localparam ST_ADDR = 6'h02;
  localparam ST_WR   = 6'h04;
  localparam ST_RD   = 6'h08;
  localparam ST_MACK = 6'h10;
  localparam ST_WAIT = 6'h20;

  // Two-stage synchronisers for pins
  reg [1:0] scl_sync;
  reg [1:0] sda_sync;
  reg [1:0] sel_sync0;
  reg [1:0] sel_sync1;
  reg       scl_d;
  reg       sda_d;
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      scl_sync  <= 2'h3;
      sda_sync  <= 2'h3;
      sel_sync0 <= 2'h0;
      sel_sync1 <= 2'h0;
      scl_d     <= 1'b1;
      sda_d     <= 1'b1;
    end else begin
      scl_sync  <= {scl_sync[0], scl_in};
      sda_sync  <= {sda_sync[0], sda_in};
      sel_sync0 <= {sel_sync0[0], addr_select_bit0_pin};
      sel_sync1 <= {sel_sync1[0], addr_select_bit1_pin};
      scl_d     <= scl_sync[1];
      sda_d     <= sda_sync[1];
    end
  end

  wire scl = scl_sync[1];
  wire sda = sda_sync[1];
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start_det = scl & scl_d & sda_d & ~sda;
  wire stop_det  = scl & scl_d & ~sda_d & sda;
  wire [6:0] my_addr = {`ADDR_UPPER, sel_sync1[1], sel_sync0[1]};

  reg [5:0]  state;
  reg [3:0]  bitcnt;     // 0..7 data bits, 8 is the ack slot
  reg [7:0]  shreg;
  reg        rw;
  reg        drive_low;
  reg [7:0]  reg_ptr;
  reg [1:0]  wr_phase;   // 0 address, 1 high byte, 2 low byte
  reg [7:0]  hi_byte;
  reg        rd_lo;
  reg [15:0] rd_word;
  reg        system_interrupt_reg_read;

  // Read mux of the status registers
  function [15:0] read_reg;
    input [7:0] a;
    begin
      case (a)
        `REG_ID:     read_reg = ID_CODE;
        `REG_SYSTEM_INTERRUPT_REG: read_reg = {1'b0, undervoltage_int_flag, 14'h0000};
        `REG_SUPPLY: read_reg = {6'h00, supply_level_code};
        `REG_HEAT:   read_reg = {{8{die_heat_code[7]}}, die_heat_code};
        default:     read_reg = 16'h0000;
      endcase
    end
  endfunction

  // Word at the pointer and at the next offset, loaded into the shifter
  wire [15:0] rd_cur  = read_reg(reg_ptr);
  wire [15:0] rd_next = read_reg(reg_ptr + 8'h01);

  assign sda_out  = 1'b0;
  assign sda_oe_n = ~drive_low;  // Open drain: only ever pulls low
  assign busy     = (state != ST_IDLE);

  // Protocol engine; actions on SCL edges, drive changes on falling edge
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      state       <= ST_IDLE;
      bitcnt      <= 4'h0;
      shreg       <= 8'h00;
      rw          <= 1'b0;
      drive_low   <= 1'b0;
      reg_ptr     <= 8'h00;
      wr_phase    <= 2'h0;
      hi_byte     <= 8'h00;
      rd_lo       <= 1'b0;
      rd_word     <= 16'h0000;
      wr_strobe   <= 1'b0;
      wr_addr     <= 8'h00;
      wr_data     <= 16'h0000;
      system_interrupt_reg_read <= 1'b0;
    end else begin
      wr_strobe   <= 1'b0;
      system_interrupt_reg_read <= 1'b0;
      if (start_det) begin
        // Start or repeated start; mid-transfer glitch also lands here
        state     <= ST_ADDR;
        bitcnt    <= 4'hF;  // The clock fall that ends the start wraps this to zero
        drive_low <= 1'b0;
      end else if (stop_det) begin
        state     <= ST_IDLE;
        drive_low <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: drive_low <= 1'b0;
          ST_ADDR, ST_WR: begin
            if (scl_rise && bitcnt < 4'h8)
              shreg <= {shreg[6:0], sda};
            if (scl_fall) begin
              if (bitcnt == 4'h7) begin
                bitcnt <= 4'h8;
                if (state == ST_ADDR) begin
                  if (shreg[7:1] == my_addr) begin
                    drive_low <= 1'b1;
                    rw        <= shreg[0];
                  end else
                    state <= ST_WAIT;
                end else
                  drive_low <= 1'b1;
              end else if (bitcnt == 4'h8) begin
                drive_low <= 1'b0;
                bitcnt    <= 4'h0;
                if (state == ST_ADDR) begin
                  wr_phase <= 2'h0;
                  if (rw) begin
                    state     <= ST_RD;
                    rd_word   <= rd_cur;
                    rd_lo     <= 1'b0;
                    system_interrupt_reg_read <= (reg_ptr == `REG_SYSTEM_INTERRUPT_REG);
                    drive_low <= ~rd_cur[15];
                  end else
                    state <= ST_WR;
                end else begin
                  // Byte written by master
                  case (wr_phase)
                    2'h0: begin
                      reg_ptr  <= shreg;
                      wr_phase <= 2'h1;
                    end
                    2'h1: begin
                      hi_byte  <= shreg;
                      wr_phase <= 2'h2;
                    end
                    default: begin
                      wr_strobe <= 1'b1;
                      wr_addr   <= reg_ptr;
                      wr_data   <= {hi_byte, shreg};
                      reg_ptr   <= reg_ptr + 8'h01;
                      wr_phase  <= 2'h1;
                    end
                  endcase
                end
              end else
                bitcnt <= bitcnt + 4'h1;
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              if (bitcnt == 4'h7) begin
                bitcnt    <= 4'h8;
                drive_low <= 1'b0;  // Release for master ack
                state     <= ST_MACK;
              end else begin
                bitcnt    <= bitcnt + 4'h1;
                drive_low <= ~rd_word[4'hE - bitcnt];
              end
            end
          end
          ST_MACK: begin
            if (scl_rise && bitcnt == 4'h8) begin
              if (sda)
                state <= ST_WAIT;
              else begin
                bitcnt <= 4'h9;  // Ack seen; the first bit goes out on the next fall
                if (rd_lo) begin
                  reg_ptr     <= reg_ptr + 8'h01;
                  rd_word     <= rd_next;
                  system_interrupt_reg_read <= ((reg_ptr + 8'h01) == `REG_SYSTEM_INTERRUPT_REG);
                end else
                  rd_word <= {rd_word[7:0], 8'h00};
                rd_lo <= ~rd_lo;
              end
            end else if (scl_fall && bitcnt == 4'h9) begin
              // Leading bit of the continued byte, driven while the clock is low
              state     <= ST_RD;
              bitcnt    <= 4'h0;
              drive_low <= ~rd_word[15];
            end
          end
          ST_WAIT: drive_low <= 1'b0;
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // Sticky undervoltage flag; a new event wins over the read clear
  always @(posedge sys_clk) begin
    if (!rst_n)
      undervoltage_int_flag <= 1'b0;
    else if (undervoltage_event)
      undervoltage_int_flag <= 1'b1;
    else if (system_interrupt_reg_read)
      undervoltage_int_flag <= 1'b0;
  end

endmodule

//--- dv/amp_i2c_control_slave_sva.sv
// Port checker for the two-wire control slave
`timescale 1ns/100ps
module amp_i2c_control_slave_sva (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Bus and status ports
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe_n,
  input wire undervoltage_event,
  input wire wr_strobe,
  input wire undervoltage_int_flag,
  input wire busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_od; sda_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("sda_out high");
  property p_lo; $changed(sda_oe_n) |-> !scl_in; endproperty
  a_lo: assert property (p_lo) else $error("sda moved with scl high");
  // Two sync flops plus decode, so a few cycles of slack
  property p_st; scl_in && $fell(sda_in) |-> ##[1:6] busy; endproperty
  a_st: assert property (p_st) else $error("start missed");
  property p_sp; scl_in && $rose(sda_in) |-> ##[1:6] !busy; endproperty
  a_sp: assert property (p_sp) else $error("stop missed");
  property p_ack; !sda_oe_n |-> busy; endproperty
  a_ack: assert property (p_ack) else $error("pull while idle");
  property p_uv; undervoltage_event |-> ##[1:3] undervoltage_int_flag; endproperty
  a_uv: assert property (p_uv) else $error("flag not set");
  property p_clr; $fell(undervoltage_int_flag) |-> busy; endproperty
  a_clr: assert property (p_clr) else $error("flag cleared idle");
  property p_wr; wr_strobe |=> !wr_strobe; endproperty
  a_wr: assert property (p_wr) else $error("strobe too long");
  c_wr: cover property (wr_strobe);
  c_clr: cover property ($fell(undervoltage_int_flag));
  c_ack: cover property (!sda_oe_n);
endmodule

//--- dv/bus_master.sv
// Two-wire bus master model, 320 ns bit period
`timescale 1ns/100ps
module bus_master (
  // Pacing clock and line read-back
  input  wire  sys_clk,
  input  wire  sda,
  // Driven lines, idle high
  output logic scl,
  output logic sda_drv
);
  logic r;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Quarter bit
  task q;
    repeat (2) @(posedge sys_clk);
  endtask
  // One bit; data only moves while scl is low
  task bit_io(input logic b, output logic s);
    sda_drv <= b;
    q();
    scl <= 1'b1;
    q();
    s = sda;
    q();
    scl <= 1'b0;
    q();
  endtask
  task start;
    bit_io(1'b1, r);
    sda_drv <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_drv <= 1'b0;
    q();
    scl <= 1'b0;
    q();
  endtask
  task stop;
    sda_drv <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_drv <= 1'b1;
    q();
  endtask
  // Msb first, line released in the ack slot
  task wbyte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task rbyte(input logic nack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, r);
  endtask
endmodule

//--- dv/tb_amp_i2c_control_slave.sv
// Testbench for the amplifier two-wire control slave
`timescale 1ns/100ps
module tb_amp_i2c_control_slave;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        uv_ev = 1'b0;
  logic [1:0]  strap = 2'b00;
  logic        ack;
  logic [15:0] w;
  logic [23:0] caps [0:3];
  localparam logic [15:0] ID_EXP = 16'h3C5A;  // Arbitrary identity value
  int          err_total = 0;
  int          n_checks = 0;
  int          n_wr = 0;
  wire         scl, m_sda, sda, sda_out, sda_oe_n, wr_strobe, uv_flag, busy;
  wire  [7:0]  wr_addr;
  wire  [15:0] wr_data;
  always #20 sys_clk = ~sys_clk;
  // Open-drain line with pull-up
  assign sda = m_sda & (sda_oe_n | sda_out);
  // Log write strobes
  always @(posedge sys_clk) if (wr_strobe === 1'b1) begin
    caps[n_wr[1:0]] <= {wr_addr, wr_data};
    n_wr <= n_wr + 1;
  end
  bus_master u_bus_master (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_drv(m_sda));
  amp_i2c_control_slave #(.ID_CODE(ID_EXP)) u_amp_i2c_control_slave (.sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_select_bit0_pin(strap[0]),
    .addr_select_bit1_pin(strap[1]), .undervoltage_event(uv_ev), .supply_level_code(10'h263),
    .die_heat_code(8'hE7), .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data),
    .undervoltage_int_flag(uv_flag), .busy(busy));
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask
  task addr(input logic [6:0] a, input logic rw);
    u_bus_master.start();
    u_bus_master.wbyte({a, rw}, ack);
  endtask
  task set_ptr(input logic [7:0] r);
    addr({5'h0D, strap}, 1'b0);
    u_bus_master.wbyte(r, ack);
  endtask
  task rd_word(input logic nack);
    u_bus_master.rbyte(1'b0, w[15:8]);
    u_bus_master.rbyte(nack, w[7:0]);
  endtask
  // Each strap, then a foreign address whose bytes are ignored
  task t_straps;
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk) strap <= i[1:0];
      repeat (4) @(posedge sys_clk);
      addr({5'h0D, i[1:0]}, 1'b0);
      chk("match", 16'h0001, {15'h0000, ack});
      u_bus_master.stop();
      addr({5'h0D, ~i[1:0]}, 1'b0);
      chk("foreign", 16'h0000, {15'h0000, ack});
      u_bus_master.wbyte(8'h10, ack);
      chk("ignored", 16'h0000, {15'h0000, ack});
      u_bus_master.stop();
    end
  endtask
  task t_write;
    set_ptr(8'h10);
    u_bus_master.wbyte(8'hAB, ack);
    u_bus_master.wbyte(8'hCD, ack);
    u_bus_master.wbyte(8'h12, ack);
    u_bus_master.wbyte(8'h34, ack);
    u_bus_master.stop();
    chk("word0", 16'hABCD, caps[0][15:0]);
    chk("ptr", 16'h1011, {caps[0][23:16], caps[1][23:16]});
    chk("word1", 16'h1234, caps[1][15:0]);
  endtask
  // Repeated start, continued read, nack ends it
  task t_read;
    set_ptr(8'h21);
    addr({5'h0D, strap}, 1'b1);
    rd_word(1'b0);
    chk("supply", 16'h0263, w);
    rd_word(1'b1);
    chk("heat", 16'hFFE7, w);
    repeat (8) @(posedge sys_clk);
    chk("release", 16'h0001, {15'h0000, sda_oe_n});
    u_bus_master.stop();
  endtask
  // Identity word, then the unmapped next offset reads zero
  task t_id;
    set_ptr(8'h00);
    addr({5'h0D, strap}, 1'b1);
    rd_word(1'b0);
    chk("id", ID_EXP, w);
    rd_word(1'b1);
    chk("unmapped", 16'h0000, w);
    u_bus_master.stop();
  endtask
  task t_uv;
    @(posedge sys_clk) uv_ev <= 1'b1;
    @(posedge sys_clk) uv_ev <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("flag", 16'h0001, {15'h0000, uv_flag});
    set_ptr(8'h02);
    u_bus_master.stop();
    addr({5'h0D, strap}, 1'b1);
    rd_word(1'b1);
    u_bus_master.stop();
    chk("system_interrupt_reg", 16'h4000, w);
    chk("cleared", 16'h0000, {15'h0000, uv_flag});
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_straps();
    t_write();
    t_read();
    t_id();
    t_uv();
    give_verdict();
  end
  // Bus traffic needs about 3000 cycles
  initial begin
    #400000;
    err_total++;
    give_verdict();
  end
endmodule
bind amp_i2c_control_slave amp_i2c_control_slave_sva u_sva (.sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .undervoltage_event(undervoltage_event),
  .wr_strobe(wr_strobe), .undervoltage_int_flag(undervoltage_int_flag), .busy(busy));
